//--- logic/aux_uv_fault_and_write_guard.sv
// Aux undervoltage fault response and command write protection
// Function
// - Aux undervoltage action byte, read-write, resets to continuous retry, write protected.
// - Action byte all zeros disables aux undervoltage handling; response code 01 unused.
// - Response 10 shuts output at once, then retries per bits 5:3.
// - Response 11 holds output off until voltage above 105% of limit.
// - Active fault pulls alert low, sets status bit; only clear-faults clears it.
// - Retry 000 latches output off until fault cleared; 001 to 110 unused.
// - Retry 111 restarts repeatedly until commanded off or another fault.
// - Continuous retry starts only after voltage rises above 105% of limit.
// - Restart spacing is (delay field plus one) times 35 ms.
// - One mask bit per command gates writes; reads are always allowed.
// - Writes to masked commands refused until a password raises authority.
// - Default-store mask clear needs default-store private password.
// - User-store mask clear alone needs user-store private password.
// - Four authority levels; 0 and 1 by public, higher by private password.
// - A private password write never lowers the authority level.
// - A public password write sets the level to 0 or 1.
// - Authority level is a read-only byte, unprotected, resetting to 01h.
// - Matching user-store public password gives level 1; default one ignored.
// - Mismatching public password drops level to 0.
// - Mask holds 256 bits; command 00h is bit 0.
//
// Decided for this implementation: the address-and-strobe port.
`include "guard_defines.svh"

module aux_uv_fault_and_write_guard
    import guard_pkg::*;
#(
    parameter int UNIT_CYCLES = `RETRY_UNIT_NS / `CLK_PERIOD_NS
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Register port
    input  wire bus_req_t    bus_req,
    output logic [31:0]      rdata_q,
    // Store images
    input  wire store_t      user_store,
    input  wire store_t      dflt_store,
    input  wire logic [31:0] user_pub_pw,
    // Monitor comparators
    input  wire logic        aux_uv_fault,
    input  wire logic        aux_uv_recovered,
    // Run control
    input  wire logic        ctrl_pin,
    input  wire logic        op_on,
    input  wire logic        other_fault_off,
    // Output stage and alert
    output logic             output_enable,
    output logic             alert_line_n_o,
    output logic             alert_line_n_oe
);

    uv_state_t   state_q;
    logic [7:0]  action_q;
    auth_t       auth_q;
    logic [1:0]  stat_q;
    logic        ctrl_s1_q;
    logic        ctrl_s2_q;
    logic        ctrl_s3_q;
    logic        ctrl_q;
    logic [31:0] unit_cnt_q;
    logic [2:0]  units_q;
    logic        unit_tick;
    logic        run_cmd;
    logic        fault_evt;
    logic        wr_ok;
    logic        wr_take;
    logic        clear_evt;
    logic        deny_evt;
    logic [1:0]  resp;
    logic [2:0]  retry;
    logic [2:0]  delay;

    // Live fields of the action byte
    assign resp  = action_q[`RESP_HI:`RESP_LO];
    assign retry = action_q[`RETRY_HI:`RETRY_LO];
    assign delay = action_q[`DELAY_HI:`DELAY_LO];

    // Write permission from authority and both masks
    always_comb
    begin
        logic d;
        logic u;
        d = dflt_store.mask[bus_req.addr];
        u = user_store.mask[bus_req.addr];
        wr_ok = 1'b0;
        if (bus_req.addr == `CMD_PUB_PW || bus_req.addr == `CMD_PRIV_PW)
        begin
            wr_ok = 1'b1;
        end
        else if (auth_q == `AUTH_VENDOR)
        begin
            wr_ok = 1'b1;
        end
        else if (auth_q == `AUTH_USER)
        begin
            wr_ok = d;
        end
        else if (auth_q == `AUTH_PUBLIC)
        begin
            wr_ok = d & u;
        end
    end

    // Accepted and refused writes
    assign wr_take   = bus_req.wr & wr_ok;
    assign deny_evt  = bus_req.wr & ~wr_ok;
    assign clear_evt = wr_take && bus_req.addr == `CMD_CLEAR_FAULTS;

    // Control pin: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_s1_q <= 1'b0;
            ctrl_s2_q <= 1'b0;
            ctrl_s3_q <= 1'b0;
            ctrl_q    <= 1'b0;
        end
        else
        begin
            ctrl_s1_q <= ctrl_pin;
            ctrl_s2_q <= ctrl_s1_q;
            ctrl_s3_q <= ctrl_s2_q;
            if (ctrl_s2_q == ctrl_s3_q)
            begin
                ctrl_q <= ctrl_s3_q;
            end
        end
    end

    // Commanded on by pin and operation, not shut by another fault
    assign run_cmd = ctrl_q & op_on & ~other_fault_off;

    // Action byte; refused writes leave it as it was
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            action_q <= `UV_ACTION_RST;
        end
        else if (wr_take && bus_req.addr == `CMD_UV_ACTION)
        begin
            action_q <= bus_req.wdata[7:0];
        end
    end

    // Authority level, changed only by password writes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            auth_q <= `AUTH_RST;
        end
        else if (bus_req.wr && bus_req.addr == `CMD_PUB_PW)
        begin
            // Only the user-store public password counts
            if (bus_req.wdata == user_pub_pw)
            begin
                auth_q <= `AUTH_PUBLIC;
            end
            else
            begin
                auth_q <= `AUTH_NONE;
            end
        end
        else if (bus_req.wr && bus_req.addr == `CMD_PRIV_PW)
        begin
            // Private passwords only ever raise the level
            if (bus_req.wdata == dflt_store.priv_pw)
            begin
                auth_q <= `AUTH_VENDOR;
            end
            else if (bus_req.wdata == user_store.priv_pw && auth_q < `AUTH_USER)
            begin
                auth_q <= `AUTH_USER;
            end
        end
    end

    // Fault is acted on only while running and not ignored
    assign fault_evt = state_q == UV_RUN && run_cmd && aux_uv_fault
                       && resp != `RESP_IGNORE && resp != `RESP_UNUSED;

    // Response sequencer
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= UV_RUN;
        end
        else
        begin
            case (state_q)
                UV_RUN:
                begin
                    if (fault_evt && resp == `RESP_HOLD)
                    begin
                        state_q <= UV_HOLD;
                    end
                    else if (fault_evt && retry == `RETRY_CONT)
                    begin
                        state_q <= UV_WAIT;
                    end
                    else if (fault_evt)
                    begin
                        state_q <= UV_LATCH;
                    end
                end
                UV_HOLD:
                begin
                    if (aux_uv_recovered)
                    begin
                        state_q <= UV_RUN;
                    end
                end
                UV_LATCH:
                begin
                    // Leaves only when the fault status is cleared
                    if (clear_evt)
                    begin
                        state_q <= UV_RUN;
                    end
                end
                UV_WAIT:
                begin
                    if (!run_cmd)
                    begin
                        state_q <= UV_RUN;
                    end
                    else if (aux_uv_recovered)
                    begin
                        state_q <= UV_DELAY;
                    end
                end
                UV_DELAY:
                begin
                    // Restart without rechecking the fault
                    if (!run_cmd)
                    begin
                        state_q <= UV_RUN;
                    end
                    else if (unit_tick && units_q == delay)
                    begin
                        state_q <= UV_RUN;
                    end
                end
                default:
                begin
                    state_q <= UV_RUN;
                end
            endcase
        end
    end

    // Retry unit divider; runs only while delaying to save toggling
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || state_q != UV_DELAY || unit_tick)
        begin
            unit_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            unit_cnt_q <= unit_cnt_q + 32'h0000_0001;
        end
    end

    assign unit_tick = state_q == UV_DELAY && unit_cnt_q == 32'(UNIT_CYCLES - 1);

    // Unit count: delay field plus one units before restart
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || state_q != UV_DELAY)
        begin
            units_q <= 3'h0;
        end
        else if (unit_tick)
        begin
            units_q <= units_q + 3'h1;
        end
    end

    // Fault status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stat_q <= 2'h0;
        end
        else
        begin
            if (fault_evt)
            begin
                stat_q[`STAT_UV_BIT] <= 1'b1;
            end
            else if (clear_evt)
            begin
                stat_q[`STAT_UV_BIT] <= 1'b0;
            end
            if (deny_evt)
            begin
                stat_q[`STAT_DENY_BIT] <= 1'b1;
            end
            else if (clear_evt)
            begin
                stat_q[`STAT_DENY_BIT] <= 1'b0;
            end
        end
    end

    // Output stage enable and open-drain alert
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            output_enable   <= 1'b0;
            alert_line_n_oe <= 1'b0;
        end
        else
        begin
            output_enable   <= state_q == UV_RUN && run_cmd && !fault_evt;
            alert_line_n_oe <= stat_q[`STAT_UV_BIT] | fault_evt;
        end
    end

    // Alert pin is only ever pulled low
    assign alert_line_n_o = 1'b0;

    // Read data, valid only in the cycle after the strobe; never gated by mask
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !bus_req.rd)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            case (bus_req.addr)
                `CMD_UV_ACTION:
                begin
                    rdata_q <= {24'h00_0000, action_q};
                end
                `CMD_AUTH_LEVEL:
                begin
                    rdata_q <= {30'h0000_0000, auth_q};
                end
                `CMD_FAULT_STAT:
                begin
                    rdata_q <= {30'h0000_0000, stat_q};
                end
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

//--- logic/guard_defines.svh
// Command codes, field positions, reset values and timing for the guard block
`ifndef GUARD_DEFINES_SVH
`define GUARD_DEFINES_SVH

// Command codes on the register port
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_FAULT_STAT    8'hE0
`define CMD_UV_ACTION     8'hF9
`define CMD_AUTH_LEVEL    8'hFA
`define CMD_PRIV_PW       8'hFB
`define CMD_PUB_PW        8'hFC

// Reset values
`define UV_ACTION_RST     8'hBF
`define AUTH_RST          2'h1

// Fault action fields
`define RESP_HI           7
`define RESP_LO           6
`define RETRY_HI          5
`define RETRY_LO          3
`define DELAY_HI          2
`define DELAY_LO          0
`define RESP_IGNORE       2'h0
`define RESP_UNUSED       2'h1
`define RESP_RETRY        2'h2
`define RESP_HOLD         2'h3
`define RETRY_NONE        3'h0
`define RETRY_CONT        3'h7

// Authority levels
`define AUTH_NONE         2'h0
`define AUTH_PUBLIC       2'h1
`define AUTH_USER         2'h2
`define AUTH_VENDOR       2'h3

// Fault status bits
`define STAT_UV_BIT       0
`define STAT_DENY_BIT     1

// Retry time unit and clock period
`define RETRY_UNIT_NS     35000000
`define CLK_PERIOD_NS     5

`endif

//--- logic/guard_pkg.sv
// Types shared by the aux undervoltage and write guard block
package guard_pkg;

    // One register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // One nonvolatile store image
    typedef struct packed {
        logic [255:0] mask;
        logic [31:0]  priv_pw;
    } store_t;

    typedef logic [1:0] auth_t;

    // Undervoltage response sequencer
    typedef enum logic [2:0] {
        UV_RUN   = 3'b000,
        UV_HOLD  = 3'b001,
        UV_LATCH = 3'b010,
        UV_WAIT  = 3'b011,
        UV_DELAY = 3'b100
    } uv_state_t;

endpackage

//--- tb/guard_checker.sv
// Port assertions for the aux undervoltage and write guard block
`include "guard_defines.svh"

module guard_checker
    import guard_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Register port
    input wire bus_req_t    bus_req,
    input wire logic [31:0] rdata_q,
    // Run control
    input wire logic        op_on,
    input wire logic        other_fault_off,
    // Output stage and alert
    input wire logic        output_enable,
    input wire logic        alert_line_n_o,
    input wire logic        alert_line_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Read data only in the cycle after a read strobe
    rd_idle_zero_a: assert property (!$past(bus_req.rd) |-> rdata_q == 32'h0)
        else $error("read data outside read slot");
    // Public password write, a gap, then a level read: the level is 0 or 1
    auth_range_a: assert property ((bus_req.wr && bus_req.addr == `CMD_PUB_PW) ##1 !bus_req.wr
        ##1 (bus_req.rd && bus_req.addr == `CMD_AUTH_LEVEL) |=> rdata_q[31:1] == 31'h0)
        else $error("level above public after public password");
    action_byte_a: assert property (bus_req.rd && bus_req.addr == `CMD_UV_ACTION |=> rdata_q[31:8] == 24'h0)
        else $error("action byte wider than one byte");
    // Alert is open drain, pulled low only
    alert_pin_a: assert property (alert_line_n_o == 1'b0)
        else $error("alert drives high");
    alert_sticky_a: assert property ($fell(alert_line_n_oe) |->
        $past(bus_req.wr && bus_req.addr == `CMD_CLEAR_FAULTS)
        || $past(bus_req.wr && bus_req.addr == `CMD_CLEAR_FAULTS, 2))
        else $error("alert released without clear");
    alert_shut_a: assert property ($rose(alert_line_n_oe) |-> !output_enable)
        else $error("alert without shutdown");
    // Commanded off or foreign shutdown stops the output
    op_off_a: assert property (!op_on |=> !output_enable)
        else $error("output on while commanded off");
    other_off_a: assert property (other_fault_off |=> !output_enable)
        else $error("output on after other fault");
endmodule

bind aux_uv_fault_and_write_guard guard_checker chk (.clk_sys, .rst_n, .bus_req, .rdata_q, .op_on,
    .other_fault_off, .output_enable, .alert_line_n_o, .alert_line_n_oe);

//--- tb/guard_host.sv
// Management bus host model driving the register port
module guard_host
    import guard_pkg::*;
(
    // Clock
    input wire logic        clk_sys,
    // Register port
    output bus_req_t        bus_req,
    input wire logic [31:0] rdata_q
);
    timeunit 1ns;
    timeprecision 1ps;

    initial bus_req = '0;

    // Released fields invert so stale values never look held
    task automatic idle();
        bus_req.addr  <= ~bus_req.addr;
        bus_req.wdata <= ~bus_req.wdata;
        bus_req.wr    <= 1'b0;
        bus_req.rd    <= 1'b0;
    endtask

    // One-cycle write, no wait state
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        idle();
    endtask

    // One-cycle read, data taken mid-cycle after the strobe
    task automatic get(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, ~bus_req.wdata, 1'b0, 1'b1};
        @(posedge clk_sys);
        idle();
        @(negedge clk_sys);
        d = rdata_q;
    endtask
endmodule

//--- tb/aux_uv_fault_and_write_guard_test.sv
// Self-checking bench for the aux undervoltage and write guard block
`include "guard_defines.svh"
`define CHK(n, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("unexpected %s: expected %0h, seen %0h", n, e, g); \
        end \
    end

module aux_uv_fault_and_write_guard_test;
    import guard_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int U = 10;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    bus_req_t    bus_req;
    logic [31:0] rdata_q;
    store_t      user_store;
    store_t      dflt_store;
    logic [31:0] user_pub_pw;
    logic        aux_uv_fault = 1'b0;
    logic        aux_uv_recovered = 1'b0;
    logic        ctrl_pin = 1'b1;
    logic        op_on = 1'b1;
    logic        other_fault_off = 1'b0;
    logic        output_enable;
    logic        alert_line_n_o;
    logic        alert_line_n_oe;
    int          n_fail = 0;
    int          checks_done = 0;
    int          n;
    logic [31:0] seed = 32'h00011A04;
    logic [31:0] rd_v;
    logic [7:0]  act_exp = 8'hBF;
    logic        ok;
    logic [2:0]  d;

    always #2.5 clk_sys = ~clk_sys;

    // Short retry unit keeps the run brief
    aux_uv_fault_and_write_guard #(.UNIT_CYCLES(U)) DUT (.clk_sys, .rst_n, .bus_req, .rdata_q, .user_store,
        .dflt_store, .user_pub_pw, .aux_uv_fault, .aux_uv_recovered, .ctrl_pin, .op_on, .other_fault_off,
        .output_enable, .alert_line_n_o, .alert_line_n_oe);
    guard_host host (.clk_sys, .bus_req, .rdata_q);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected write permission for the action byte
    function automatic logic may_wr(input logic [1:0] lv, input logic u, input logic f);
        return lv == 2'h3 || (lv == 2'h2 && f) || (lv == 2'h1 && u && f);
    endfunction

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_rd(input string s, input logic [7:0] a, input logic [31:0] e);
        host.get(a, rd_v);
        `CHK(s, e, rd_v)
    endtask

    task automatic set_lv(input logic [1:0] lv);
        host.put(`CMD_PUB_PW, lv == 2'h0 ? ~user_pub_pw : user_pub_pw);
        if (lv == 2'h2)
            host.put(`CMD_PRIV_PW, user_store.priv_pw);
        if (lv == 2'h3)
            host.put(`CMD_PRIV_PW, dflt_store.priv_pw);
    endtask

    // Bounded wait for the output to reach a level
    task automatic wait_en(input int lim);
        n = 0;
        while (output_enable !== 1'b1 && n < lim)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (output_enable !== 1'b1)
        begin
            n_fail++;
            $display("unexpected wait: output never enabled");
            end_of_test();
        end
    endtask

    task automatic fault();
        @(posedge clk_sys);
        aux_uv_fault <= 1'b1;
        @(posedge clk_sys);
        aux_uv_fault <= 1'b0;
        @(negedge clk_sys);
    endtask

    initial
    begin
        seed = lfsr(seed);
        user_pub_pw = seed;
        seed = lfsr(seed);
        user_store = '{'1, seed};
        dflt_store = '{'1, ~seed};
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_rd("action", `CMD_UV_ACTION, 32'h000000BF);
        chk_rd("level", `CMD_AUTH_LEVEL, 32'h00000001);
        chk_rd("unmapped", 8'h10, 32'h00000000);
        $display("test reset done");
        // Every mask pairing at every level
        for (int c = 0; c < 4; c++)
            for (int lv = 0; lv < 4; lv++)
            begin
                @(posedge clk_sys);
                user_store.mask[`CMD_UV_ACTION] <= c[0];
                dflt_store.mask[`CMD_UV_ACTION] <= c[1];
                set_lv(2'(lv));
                chk_rd("level", `CMD_AUTH_LEVEL, 32'(lv));
                seed = lfsr(seed);
                ok = may_wr(2'(lv), c[0], c[1]);
                host.put(`CMD_UV_ACTION, {24'h0, seed[7:0]});
                if (ok)
                    act_exp = seed[7:0];
                chk_rd("action", `CMD_UV_ACTION, 32'(act_exp));
                if (!ok)
                    chk_rd("deny", `CMD_FAULT_STAT, 32'h2);
            end
        @(posedge clk_sys);
        user_store.mask <= '1;
        dflt_store.mask <= '1;
        set_lv(2'h3);
        host.put(`CMD_PRIV_PW, user_store.priv_pw);
        chk_rd("level", `CMD_AUTH_LEVEL, 32'h3);
        host.put(`CMD_PUB_PW, ~user_pub_pw);
        chk_rd("level", `CMD_AUTH_LEVEL, 32'h0);
        host.put(`CMD_PUB_PW, user_pub_pw);
        host.put(`CMD_AUTH_LEVEL, 32'h0);
        chk_rd("level", `CMD_AUTH_LEVEL, 32'h1);
        $display("test protection done");
        set_lv(2'h3);
        host.put(`CMD_CLEAR_FAULTS, 32'h0);
        // Ignored responses leave the output alone
        for (int i = 0; i < 2; i++)
        begin
            host.put(`CMD_UV_ACTION, {25'h0, 1'(i), 6'h0});
            wait_en(20);
            fault();
            repeat (3) @(negedge clk_sys);
            `CHK("enable", 1'b1, output_enable)
            `CHK("alert", 1'b0, alert_line_n_oe)
        end
        // Hold off until the voltage has recovered
        host.put(`CMD_UV_ACTION, 32'hC0);
        fault();
        `CHK("enable", 1'b0, output_enable)
        `CHK("alert", 1'b1, alert_line_n_oe)
        chk_rd("status", `CMD_FAULT_STAT, 32'h1);
        @(posedge clk_sys);
        aux_uv_recovered <= 1'b1;
        wait_en(4);
        @(posedge clk_sys);
        aux_uv_recovered <= 1'b0;
        `CHK("alert", 1'b1, alert_line_n_oe)
        host.put(`CMD_CLEAR_FAULTS, 32'h0);
        repeat (3) @(negedge clk_sys);
        `CHK("alert", 1'b0, alert_line_n_oe)
        // No retry latches off until cleared
        host.put(`CMD_UV_ACTION, 32'h80);
        fault();
        `CHK("enable", 1'b0, output_enable)
        @(posedge clk_sys);
        aux_uv_recovered <= 1'b1;
        repeat (3 * U) @(negedge clk_sys);
        `CHK("enable", 1'b0, output_enable)
        @(posedge clk_sys);
        aux_uv_recovered <= 1'b0;
        host.put(`CMD_CLEAR_FAULTS, 32'h0);
        wait_en(8);
        $display("test responses done");
        // Continuous retry spacing at both ends and one random delay
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            d = i == 0 ? 3'h0 : (i == 1 ? 3'h7 : seed[2:0]);
            host.put(`CMD_UV_ACTION, {24'h0, 5'h17, d});
            fault();
            repeat (3 * U) @(negedge clk_sys);
            `CHK("enable", 1'b0, output_enable)
            @(posedge clk_sys);
            aux_uv_recovered <= 1'b1;
            wait_en(120);
            `CHK("spacing", 1'b1, n >= (d + 1) * U && n <= (d + 1) * U + 4)
            @(posedge clk_sys);
            aux_uv_recovered <= 1'b0;
            host.put(`CMD_CLEAR_FAULTS, 32'h0);
        end
        // Control pin low, through the synchroniser, turns the output off
        @(posedge clk_sys);
        ctrl_pin <= 1'b0;
        repeat (8) @(negedge clk_sys);
        `CHK("enable", 1'b0, output_enable)
        @(posedge clk_sys);
        ctrl_pin <= 1'b1;
        wait_en(10);
        // Commanded off and foreign shutdown
        @(posedge clk_sys);
        op_on <= 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK("enable", 1'b0, output_enable)
        @(posedge clk_sys);
        op_on <= 1'b1;
        other_fault_off <= 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("enable", 1'b0, output_enable)
        @(posedge clk_sys);
        other_fault_off <= 1'b0;
        // Commanded off ends a retry wait; back on, it runs without recovery
        host.put(`CMD_UV_ACTION, 32'hBF);
        fault();
        @(posedge clk_sys);
        op_on <= 1'b0;
        @(posedge clk_sys);
        op_on <= 1'b1;
        wait_en(10);
        $display("test retry done");
        end_of_test();
    end
endmodule
